// [design/abs_pkg.sv]
// Shared constants and types of the converter board bus sequencer.
// Assumes one 10 MHz clock and a 16-bit short I/O slave.
package abs_pkg;

  // ==========================================================
  // Timing
  localparam longint CLK_HZ        = 10_000_000;
  localparam int     SETTLE_X1_NS  = 8_000;
  localparam int     SETTLE_X10_NS = 20_000;
  localparam int     SETTLE_X100_NS = 60_000;
  localparam int     SETTLE_X500_NS = 120_000;
  localparam int     TRACK_NS      = 2_000;
  localparam int     CONV_NS       = 19_000;
  localparam int     TMR_W         = 11;

  // Least time in ns to whole clock cycles, rounded up
  function automatic logic [TMR_W-1:0] abs_cyc(input int ns);
    longint c;
    c = (longint'(ns) * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
    if (c < 1) c = 1;
    return c[TMR_W-1:0];
  endfunction : abs_cyc

  localparam logic [TMR_W-1:0] TRACK_CYC = abs_cyc(TRACK_NS);
  localparam logic [TMR_W-1:0] CONV_CYC  = abs_cyc(CONV_NS);

  // ==========================================================
  // Register byte offsets within the 32-byte window
  localparam logic [4:0] OFS_CSR  = 5'h00;
  localparam logic [4:0] OFS_DATA = 5'h02;
  localparam logic [4:0] OFS_AO0  = 5'h04;
  localparam logic [4:0] OFS_AO1  = 5'h06;
  localparam logic [4:0] OFS_GAIN = 5'h0E;
  localparam logic [4:0] OFS_INTA = 5'h10;
  localparam logic [4:0] OFS_INTB = 5'h18;

  // Mode control fields
  localparam int CH_W       = 5;
  localparam int FRONT_BIT  = 7;
  localparam int MODE_LSB   = 8;
  localparam int SETTLE_BIT = 11;
  localparam int ARM_BIT    = 12;
  localparam int PIPE_BIT   = 13;
  localparam int ROUTE_MSB  = 10;
  // Status fields
  localparam int ST_PIPE    = 11;
  localparam int ST_SETTLE  = 12;
  localparam int ST_CONV    = 13;
  localparam int ST_VALID   = 14;
  localparam int ST_DONE_N  = 15;
  // Interrupter field, output and converter widths
  localparam int INT_EN_BIT = 4;
  localparam int AO_W       = 12;
  localparam int ADC_W      = 12;

  localparam logic [5:0] AM_NONPRIV = 6'h29;
  localparam logic [5:0] AM_SUPER   = 6'h2D;

  // ==========================================================
  // Types
  typedef struct packed {
    logic        asN;
    logic [1:0]  dsN;
    logic        writeN;
    logic        iackN;
    logic        iackInN;
    logic [15:1] addr;
    logic [5:0]  am;
    logic [15:0] data;
    logic        doneN;
    logic [ADC_W-1:0] adc;
  } abs_pin_t;

  typedef enum logic [1:0] {
    S_IDLE   = 2'h0,
    S_SETTLE = 2'h1,
    S_TRACK  = 2'h3
  } abs_settle_t;

  typedef enum logic {
    C_IDLE = 1'b0,
    C_CONV = 1'b1
  } abs_conv_t;

endpackage : abs_pkg

// [design/abs_sequencer.sv]
// Bus slave, conversion sequencer, result FIFO and interrupter.
// Assumes backplane pins arrive asynchronous; clk is the system clock.
`timescale 1ns/1ps

// ==========================================================
// Result FIFO
module abs_fifo #(
  parameter int W = 12,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } abs_fifo_st_t;

  abs_fifo_st_t st_r;
  abs_fifo_st_t st_nxt;
  logic         push;
  logic         pop;

  assign inReady  = st_r.cnt != (AW+1)'(D);
  assign outValid = st_r.cnt != '0;
  assign outData  = st_r.mem[st_r.rp];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = inData;
      st_nxt.wp = (st_r.wp == AW'(D-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(D-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : abs_fifo

// ==========================================================
// Top
module abs_sequencer #(
  parameter int FIFO_D = 4
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire abs_pkg::abs_pin_t pins,
  input  wire logic [15:5]      boardBase,
  input  wire logic             superSel,
  output logic [15:0]           dataOut,
  output logic                  dataOe,
  output logic                  dtackOut,
  output logic                  dtackOe,
  output logic [7:1]            irqOe,
  output logic                  iackOutN,
  output logic [4:0]            chanSel,
  output logic                  frontSel,
  output logic [2:0]            netMode,
  output logic [1:0]            gainSel,
  output logic                  holdMode,
  output logic                  convertTrigger,
  output logic [11:0]           aoCode0,
  output logic [11:0]           aoCode1
);
  typedef struct packed {
    abs_pkg::abs_pin_t s1;
    abs_pkg::abs_pin_t s2;
    logic [15:0]       ctl;
    logic [15:0]       gain;
    logic [15:0]       intA;
    logic [15:0]       intB;
    logic [11:0]       ao0;
    logic [11:0]       ao1;
    logic              cycDone;
    logic              dtack;
    logic              rdOe;
    logic [15:0]       rdData;
    abs_pkg::abs_settle_t sst;
    abs_pkg::abs_conv_t   cst;
    logic [abs_pkg::TMR_W-1:0] sTmr;
    logic [abs_pkg::TMR_W-1:0] cTmr;
    logic              settleReq;
    logic              settleAct;
    logic              convAct;
    logic              valid;
    logic              armed;
    logic              trig;
    logic              irqPend;
  } abs_st_t;

  localparam abs_st_t ST_RESET = '{s1: '1, s2: '1, sst: abs_pkg::S_IDLE,
                                   cst: abs_pkg::C_IDLE, default: '0};
  localparam logic [3:0][abs_pkg::TMR_W-1:0] SETTLE_CYC = {
    abs_pkg::abs_cyc(abs_pkg::SETTLE_X500_NS),
    abs_pkg::abs_cyc(abs_pkg::SETTLE_X100_NS),
    abs_pkg::abs_cyc(abs_pkg::SETTLE_X10_NS),
    abs_pkg::abs_cyc(abs_pkg::SETTLE_X1_NS)};

  // Byte-lane write merge: DS0 low byte, DS1 high byte
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0]  dsN);
    logic [15:0] r;
    r = old;
    if (!dsN[0]) r[7:0] = wd[7:0];
    if (!dsN[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : merge

  abs_st_t           st_r;
  abs_st_t           st_nxt;
  logic              amOk;
  logic              sel;
  logic              take;
  logic              iackSel;
  logic              strobe;
  logic [4:0]        ofs;
  logic              wrEv;
  logic              popEv;
  logic              push;
  logic              fifoReady;
  logic              fifoValid;
  logic [11:0]       fifoData;
  logic [15:0]       newCtl;
  logic [15:0]       newGain;
  logic [15:0]       newAo0;
  logic [15:0]       newAo1;
  logic              startSettle;
  logic [2:0]        lvl;

  // ==========================================================
  // Decode
  assign strobe = !st_r.s2.asN && st_r.s2.dsN != 2'h3;
  assign amOk   = st_r.s2.am == (superSel ? abs_pkg::AM_SUPER
                                          : abs_pkg::AM_NONPRIV);
  assign sel    = strobe && st_r.s2.iackN && amOk
                  && st_r.s2.addr[15:5] == boardBase;
  assign ofs    = {st_r.s2.addr[4:1], 1'b0};
  assign lvl    = st_r.intA[2:0];
  assign take   = st_r.irqPend && lvl != 3'h0
                  && st_r.s2.addr[3:1] == lvl;
  assign iackSel = strobe && !st_r.s2.iackN && !st_r.s2.iackInN && take;
  assign wrEv   = sel && !st_r.cycDone && !st_r.s2.writeN;
  assign popEv  = sel && !st_r.cycDone && st_r.s2.writeN
                  && ofs == abs_pkg::OFS_DATA;
  assign push   = st_r.cst == abs_pkg::C_CONV && st_r.cTmr == '0
                  && !st_r.s2.doneN;
  assign newCtl  = merge(st_r.ctl, st_r.s2.data, st_r.s2.dsN);
  assign newGain = merge(st_r.gain, st_r.s2.data, st_r.s2.dsN);
  assign newAo0  = merge({4'h0, st_r.ao0}, st_r.s2.data, st_r.s2.dsN);
  assign newAo1  = merge({4'h0, st_r.ao1}, st_r.s2.data, st_r.s2.dsN);
  assign startSettle = wrEv && ((ofs == abs_pkg::OFS_CSR
      && (newCtl[abs_pkg::SETTLE_BIT]
      || newCtl[abs_pkg::ROUTE_MSB:0] != st_r.ctl[abs_pkg::ROUTE_MSB:0]))
      || (ofs == abs_pkg::OFS_GAIN && newGain[1:0] != st_r.gain[1:0]));

  abs_fifo #(
    .W (abs_pkg::ADC_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .inValid  (push),
    .inReady  (fifoReady),
    .inData   (st_r.s2.adc),
    .outValid (fifoValid),
    .outReady (popEv),
    .outData  (fifoData)
  );

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.trig = 1'b0;
    // Bus cycle
    if ((sel || iackSel) && !st_r.cycDone) begin
      st_nxt.cycDone = 1'b1;
      st_nxt.dtack = 1'b1;
      st_nxt.rdOe = st_r.s2.writeN || iackSel;
      st_nxt.rdData = '0;
      if (iackSel) begin
        st_nxt.rdData = {8'h00, st_r.intB[7:0]};
        st_nxt.irqPend = 1'b0;
      end else if (st_r.s2.writeN) begin
        unique case (ofs)
          abs_pkg::OFS_CSR: st_nxt.rdData = {st_r.s2.doneN, st_r.valid,
              st_r.convAct, st_r.settleAct, st_r.ctl[abs_pkg::PIPE_BIT],
              st_r.ctl[abs_pkg::ROUTE_MSB:0]};
          abs_pkg::OFS_DATA: st_nxt.rdData = {4'h0, fifoData};
          abs_pkg::OFS_AO0:  st_nxt.rdData = {4'h0, st_r.ao0};
          abs_pkg::OFS_AO1:  st_nxt.rdData = {4'h0, st_r.ao1};
          abs_pkg::OFS_GAIN: st_nxt.rdData = st_r.gain;
          abs_pkg::OFS_INTA: st_nxt.rdData = st_r.intA;
          abs_pkg::OFS_INTB: st_nxt.rdData = st_r.intB;
          default:           st_nxt.rdData = '0;
        endcase
        if (popEv) begin
          st_nxt.valid = 1'b0;
          st_nxt.convAct = 1'b0;
        end
      end else begin
        unique case (ofs)
          abs_pkg::OFS_CSR: begin
            st_nxt.ctl = newCtl;
            st_nxt.ctl[abs_pkg::SETTLE_BIT] = 1'b0;
            st_nxt.ctl[abs_pkg::ARM_BIT] = 1'b0;
            if (newCtl[abs_pkg::ARM_BIT]) begin
              st_nxt.armed = 1'b1;
              st_nxt.convAct = 1'b1;
            end
          end
          abs_pkg::OFS_AO0:  st_nxt.ao0 = newAo0[abs_pkg::AO_W-1:0];
          abs_pkg::OFS_AO1:  st_nxt.ao1 = newAo1[abs_pkg::AO_W-1:0];
          abs_pkg::OFS_GAIN: st_nxt.gain = newGain;
          abs_pkg::OFS_INTA: st_nxt.intA = merge(st_r.intA, st_r.s2.data,
                                                 st_r.s2.dsN);
          abs_pkg::OFS_INTB: st_nxt.intB = merge(st_r.intB, st_r.s2.data,
                                                 st_r.s2.dsN);
          default: ;
        endcase
      end
    end
    if (st_r.s2.dsN == 2'h3) begin
      st_nxt.cycDone = 1'b0;
      st_nxt.dtack = 1'b0;
      st_nxt.rdOe = 1'b0;
    end
    if (startSettle) begin
      st_nxt.settleReq = 1'b1;
    end
    // Settle and track
    unique case (st_r.sst)
      abs_pkg::S_IDLE: begin
        if (st_r.settleReq && (st_r.ctl[abs_pkg::PIPE_BIT]
            || st_r.cst == abs_pkg::C_IDLE)) begin
          st_nxt.settleReq = startSettle;
          st_nxt.sst = abs_pkg::S_SETTLE;
          st_nxt.sTmr = SETTLE_CYC[st_r.gain[1:0]];
          st_nxt.settleAct = 1'b1;
        end else if (st_r.armed && st_r.cst == abs_pkg::C_IDLE
                     && fifoReady && !st_r.settleReq) begin
          st_nxt.armed = 1'b0;
          st_nxt.trig = 1'b1;
          st_nxt.cst = abs_pkg::C_CONV;
          st_nxt.cTmr = abs_pkg::CONV_CYC;
        end
      end
      abs_pkg::S_SETTLE: begin
        if (st_r.sTmr != '0) begin
          st_nxt.sTmr = st_r.sTmr - 1'b1;
        end else begin
          st_nxt.sst = abs_pkg::S_TRACK;
          st_nxt.sTmr = abs_pkg::TRACK_CYC;
        end
      end
      abs_pkg::S_TRACK: begin
        if (st_r.cst == abs_pkg::C_IDLE) begin
          if (st_r.sTmr != '0) begin
            st_nxt.sTmr = st_r.sTmr - 1'b1;
          end else if (!st_r.armed || fifoReady) begin
            st_nxt.settleAct = 1'b0;
            st_nxt.sst = abs_pkg::S_IDLE;
            if (st_r.armed) begin
              st_nxt.armed = 1'b0;
              st_nxt.trig = 1'b1;
              st_nxt.cst = abs_pkg::C_CONV;
              st_nxt.cTmr = abs_pkg::CONV_CYC;
            end
          end
        end
      end
      default: st_nxt.sst = abs_pkg::S_IDLE;
    endcase
    // Restart at once with the gain that this write leaves in force
    if (st_r.sst != abs_pkg::S_IDLE && startSettle) begin
      st_nxt.sst = abs_pkg::S_SETTLE;
      st_nxt.sTmr = SETTLE_CYC[st_nxt.gain[1:0]];
      st_nxt.settleAct = 1'b1;
      st_nxt.settleReq = 1'b0;
    end
    // Conversion
    if (st_r.cst == abs_pkg::C_CONV) begin
      if (st_r.cTmr != '0) begin
        st_nxt.cTmr = st_r.cTmr - 1'b1;
      end else if (push) begin
        st_nxt.cst = abs_pkg::C_IDLE;
        st_nxt.valid = 1'b1;
        if (st_r.intA[abs_pkg::INT_EN_BIT]) begin
          st_nxt.irqPend = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign dataOut  = st_r.rdData;
  assign dataOe   = st_r.rdOe;
  assign dtackOut = 1'b0;
  assign dtackOe  = st_r.dtack;
  always_comb begin
    irqOe = '0;
    if (st_r.irqPend && lvl != 3'h0) begin
      irqOe[lvl] = 1'b1;
    end
  end
  // Keep the chain blocked for the rest of an acknowledge cycle we answered
  assign iackOutN = st_r.s2.iackInN
                    || (!st_r.s2.iackN && (take || st_r.cycDone));
  assign frontSel = st_r.ctl[abs_pkg::FRONT_BIT];
  assign chanSel  = frontSel ? {1'b0, st_r.ctl[3:0]}
                             : st_r.ctl[abs_pkg::CH_W-1:0];
  assign netMode  = st_r.ctl[abs_pkg::ROUTE_MSB:abs_pkg::MODE_LSB];
  assign gainSel  = st_r.gain[1:0];
  assign holdMode = st_r.cst == abs_pkg::C_CONV;
  assign convertTrigger = st_r.trig;
  assign aoCode0  = st_r.ao0;
  assign aoCode1  = st_r.ao1;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_release;
    st_r.dtack && st_r.s2.dsN == 2'h3 |=> !dtackOe;
  endproperty
  a_release: assert property (p_release) else $error("ack held");

  property p_noMatch;
    !st_r.dtack && !sel && !iackSel |=> !dtackOe;
  endproperty
  a_noMatch: assert property (p_noMatch) else $error("stray ack");

  property p_aoMask;
    wrEv && ofs == abs_pkg::OFS_AO1 && st_r.s2.dsN == 2'h0
      |=> aoCode1 == $past(st_r.s2.data[11:0]);
  endproperty
  a_aoMask: assert property (p_aoMask) else $error("ao code");

  property p_settleFlag;
    st_r.sst == abs_pkg::S_SETTLE |-> st_r.settleAct;
  endproperty
  a_settleFlag: assert property (p_settleFlag) else $error("settle flag");

  property p_trigHold;
    convertTrigger |-> holdMode ##1 holdMode[*8];
  endproperty
  a_trigHold: assert property (p_trigHold) else $error("hold");

  property p_readClear;
    popEv && !push |=> !st_r.valid && !st_r.convAct;
  endproperty
  a_readClear: assert property (p_readClear) else $error("read clear");

  property p_validSet;
    push |=> st_r.valid;
  endproperty
  a_validSet: assert property (p_validSet) else $error("valid");

  property p_arm;
    wrEv && ofs == abs_pkg::OFS_CSR && newCtl[abs_pkg::ARM_BIT]
      |=> st_r.convAct && st_r.armed;
  endproperty
  a_arm: assert property (p_arm) else $error("arm");

  property p_front;
    frontSel |-> !chanSel[4];
  endproperty
  a_front: assert property (p_front) else $error("front chan");

  property p_iackHold;
    iackSel |=> iackOutN;
  endproperty
  a_iackHold: assert property (p_iackHold) else $error("ack passed on");

  c_trig: cover property (convertTrigger);
  c_pop: cover property (popEv && fifoValid);
  c_iack: cover property (iackSel);
endmodule : abs_sequencer

// [testbench/abs_bus_master.sv]
// Bus master and converter model facing the sequencer's backplane pins.
// Assumes one clock; drives pins only at falling edges.
`timescale 1ns/1ps

module abs_bus_master #(
  parameter int CONV_LEN = 195
) (
  input  wire logic              clk,
  input  wire logic [15:0]       dataOut,
  input  wire logic              dtackOe,
  input  wire logic              convertTrigger,
  output abs_pkg::abs_pin_t      pins
);
  // ==========================================================
  // Idle bus
  initial begin
    pins         = '0;
    pins.asN     = 1'b1;
    pins.dsN     = 2'h3;
    pins.writeN  = 1'b1;
    pins.iackN   = 1'b1;
    pins.iackInN = 1'b1;
    pins.adc     = 12'h123;
  end

  // ==========================================================
  // Converter: done high while converting, new result each time
  always @(negedge clk) begin
    if (convertTrigger === 1'b1) begin
      pins.doneN = 1'b1;
      repeat (CONV_LEN) @(negedge clk);
      pins.adc   = pins.adc + 12'h111;
      pins.doneN = 1'b0;
    end
  end

  // ==========================================================
  // One bus cycle: hold until acknowledge or 12 clocks, then withdraw
  task automatic access(input bit wr, input bit iack, input logic [15:1] a,
                        input logic [15:0] wd, output logic [15:0] rd, output bit acked);
    int n;
    @(negedge clk);
    pins.addr    = a;
    pins.am      = abs_pkg::AM_NONPRIV;
    pins.writeN  = ~wr;
    pins.iackN   = ~iack;
    pins.iackInN = ~iack;
    pins.data    = wd;
    pins.asN     = 1'b0;
    pins.dsN     = 2'h0;
    acked        = 1'b0;
    rd           = '0;
    for (n = 0; n < 12 && !acked; n++) begin
      @(posedge clk);
      #1;
      if (dtackOe === 1'b1) begin
        acked = 1'b1;
        rd    = dataOut;
      end
    end
    @(negedge clk);
    pins.asN     = 1'b1;
    pins.dsN     = 2'h3;
    pins.writeN  = 1'b1;
    pins.iackN   = 1'b1;
    pins.iackInN = 1'b1;
    pins.data    = ~wd;
    pins.addr    = ~a;
    for (n = 0; n < 8 && dtackOe !== 1'b0; n++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : access
endmodule : abs_bus_master

// [testbench/abs_sequencer_tb.sv]
// Self-checking bench for the converter board sequencer.
// Assumes the bus master model in abs_bus_master.sv.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t ns: got %h expected %h", $time, (a), (e)); end end

module abs_sequencer_tb;
  logic              clk       = 1'b0;
  logic              reset_n   = 1'b0;
  logic [15:5]       boardBase = 11'h7F8;
  abs_pkg::abs_pin_t pins;
  logic [15:0]       dataOut;
  logic              dataOe, dtackOut, dtackOe, iackOutN, frontSel, holdMode, convertTrigger;
  logic [7:1]        irqOe;
  logic [4:0]        chanSel;
  logic [2:0]        netMode;
  logic [1:0]        gainSel;
  logic [11:0]       aoCode0, aoCode1;
  logic [15:0]       rv;
  bit                ack;
  int                failures  = 0;
  int                cmp_count = 0;
  int                cyc       = 0;
  int                t0, n;

  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  abs_sequencer #(.FIFO_D(4)) dut (.clk(clk), .reset_n(reset_n), .pins(pins),
    .boardBase(boardBase), .superSel(1'b0), .dataOut(dataOut), .dataOe(dataOe),
    .dtackOut(dtackOut), .dtackOe(dtackOe), .irqOe(irqOe), .iackOutN(iackOutN),
    .chanSel(chanSel), .frontSel(frontSel), .netMode(netMode), .gainSel(gainSel),
    .holdMode(holdMode), .convertTrigger(convertTrigger), .aoCode0(aoCode0),
    .aoCode1(aoCode1));

  abs_bus_master mst (.clk(clk), .dataOut(dataOut), .dtackOe(dtackOe),
    .convertTrigger(convertTrigger), .pins(pins));

  // ==========================================================
  // Register access
  task automatic wr(input logic [4:0] o, input logic [15:0] d);
    logic [15:0] x;
    bit          k;
    mst.access(1'b1, 1'b0, {boardBase, o[4:1]}, d, x, k);
    `CHK(k, 1'b1)
    `CHK(dtackOe, 1'b0)
  endtask : wr

  task automatic rd(input logic [4:0] o, output logic [15:0] d);
    bit k;
    mst.access(1'b0, 1'b0, {boardBase, o[4:1]}, 16'h0000, d, k);
    `CHK(k, 1'b1)
    `CHK(dtackOe, 1'b0)
  endtask : rd

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // Tests
  initial begin
    repeat (19) @(negedge clk);
    `CHK({dtackOe, dataOe, convertTrigger, holdMode, irqOe, iackOutN}, 12'h001)
    @(negedge clk);
    reset_n = 1'b1;
    rd(abs_pkg::OFS_CSR, rv);
    `CHK(rv, 16'h0000)
    $display("test reset done");

    mst.access(1'b1, 1'b0, {~boardBase, 4'h2}, 16'h0FFF, rv, ack);
    `CHK(ack, 1'b0)
    `CHK(aoCode0, 12'h000)
    wr(abs_pkg::OFS_AO0, 16'hFABC);
    `CHK(aoCode0, 12'hABC)
    wr(abs_pkg::OFS_AO1, 16'h5123);
    `CHK(aoCode1, 12'h123)
    rd(5'h08, rv);
    `CHK(rv, 16'h0000)
    for (int g = 3; g >= 0; g--) begin
      wr(abs_pkg::OFS_GAIN, 16'hFFFC | 16'(g));
      `CHK(gainSel, 2'(g))
    end
    $display("test registers done");

    wr(abs_pkg::OFS_CSR, 16'h0593);
    `CHK({frontSel, chanSel[3:0], netMode}, 8'h9D)
    rd(abs_pkg::OFS_CSR, rv);
    `CHK(rv[10:0], 11'h593)
    `CHK(rv[abs_pkg::ST_SETTLE], 1'b1)
    wr(abs_pkg::OFS_CSR, 16'h0015);
    `CHK({frontSel, chanSel}, 6'h15)
    repeat (200) @(negedge clk);
    rd(abs_pkg::OFS_CSR, rv);
    `CHK(rv[15:11], 5'h00)
    $display("test routing done");

    wr(abs_pkg::OFS_INTA, 16'h0013);
    wr(abs_pkg::OFS_INTB, 16'h005A);
    t0 = cyc;
    wr(abs_pkg::OFS_CSR, 16'h1815);
    rd(abs_pkg::OFS_CSR, rv);
    `CHK(rv[13:12], 2'h3)
    for (n = 0; n < 200 && convertTrigger !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    `CHK((cyc - t0 >= 100) && (cyc - t0 <= 110), 1'b1)
    @(negedge clk);
    `CHK(holdMode, 1'b1)
    rd(abs_pkg::OFS_CSR, rv);
    `CHK(rv[15:12], 4'hA)
    for (n = 0; n < 40 && rv[abs_pkg::ST_VALID] !== 1'b1; n++) rd(abs_pkg::OFS_CSR, rv);
    `CHK(rv[15:12], 4'h6)
    `CHK(irqOe, 7'h04)
    mst.access(1'b0, 1'b1, 15'h0003, 16'h0000, rv, ack);
    `CHK(ack, 1'b1)
    `CHK(rv[7:0], 8'h5A)
    `CHK(irqOe, 7'h00)
    rd(abs_pkg::OFS_DATA, rv);
    `CHK(rv[11:0], 12'h234)
    rd(abs_pkg::OFS_CSR, rv);
    `CHK(rv[14:13], 2'h0)
    $display("test conversion done");

    wr(abs_pkg::OFS_CSR, 16'h3015);
    wr(abs_pkg::OFS_CSR, 16'h2016);
    rd(abs_pkg::OFS_CSR, rv);
    `CHK(rv[13:11], 3'h7)
    for (n = 0; n < 40 && rv[abs_pkg::ST_VALID] !== 1'b1; n++) rd(abs_pkg::OFS_CSR, rv);
    rd(abs_pkg::OFS_DATA, rv);
    `CHK(rv[11:0], 12'h345)
    $display("test pipelined done");
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule : abs_sequencer_tb
